// ==== rtl/uhb_pkg.sv ====
package uhb_pkg;

	localparam int ADDR_W  = 3;
	localparam int UPPER_W = 7;
	localparam int DATA_W  = 8;

	// positions inside the synchronised pin vector
	localparam int P_SEL_A = 0;
	localparam int P_SEL_B = 1;
	localparam int P_SEL_N = 2;
	localparam int P_AS_N  = 3;
	localparam int P_RD_N  = 4;
	localparam int P_WR_N  = 5;
	localparam int P_STYLE = 6;
	localparam int P_PC_N  = 7;
	localparam int P_ADDR  = 8;
	localparam int P_UPPER = 11;
	localparam int P_DATA  = 18;
	localparam int PIN_W   = 26;

	// idle pins: selects inactive, strobes high, strobe-style bus, pc strap high
	localparam logic [PIN_W-1:0] PIN_IDLE = 26'h00000bc;

	typedef struct packed {
		logic [PIN_W-1:0]   sync1;
		logic [PIN_W-1:0]   sync2;
		logic               prevAs;
		logic               prevRd;
		logic               prevWr;
		logic               prevSel;
		logic [2:0]         latchSel;
		logic [ADDR_W-1:0]  latchAddr;
		logic [UPPER_W-1:0] latchUpper;
		logic               fresh;
		logic               rdActive;
		logic               wrActive;
		logic               regRead;
		logic               regWrite;
		logic [ADDR_W-1:0]  regAddr;
		logic [DATA_W-1:0]  regWdata;
		logic [DATA_W-1:0]  dataOut;
		logic               dataOe;
		logic               intOut;
		logic               intOe;
		logic               txRdyN;
		logic               rxRdyN;
		logic               pcMode;
		logic [UPPER_W-1:0] pcUpper;
	} uhb_state_s;

	localparam uhb_state_s ST_RESET = '{sync1: PIN_IDLE, sync2: PIN_IDLE, prevAs: 1'b1,
		prevRd: 1'b1, prevWr: 1'b1, txRdyN: 1'b1, rxRdyN: 1'b1, default: '0};

endpackage

// ==== rtl/uhb_host_port.sv ====
// How it works
// - interrupt asserts on any pending source
// - strobe mode: interrupt active high, optional open-source
// - rw-select mode: interrupt active-low open-drain
// - strobe mode: strobe edge latches selects, address
// - address captured per access with strobe tied low
// - transmit-ready low reflects transmit fill state
// - receive-ready low reflects receive fill state
// - strap_n_a needs both straps low
// - strap_n_a passes upper address to decoder
// - rw-select mode: direction high reads, low writes
// - strobe mode: read strobe fall reads addressed register onto bus
`timescale 1ns/1ps
`default_nettype none

module uhb_host_port
	import uhb_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               selectHighA,
	input  wire logic               selectHighB,
	input  wire logic               selectLowN,
	input  wire logic               addrLatchStrobeN,
	input  wire logic [ADDR_W-1:0]  addr,
	input  wire logic [UPPER_W-1:0] upperAddr,
	input  wire logic               readStrobeN,
	input  wire logic               writeStrobeN,
	input  wire logic               busStyleStrap,
	input  wire logic               strapNA,
	input  wire logic [DATA_W-1:0]  dataIn,
	output logic      [DATA_W-1:0]  dataOut,
	output logic                    dataOe,
	output logic                    regRead,
	output logic                    regWrite,
	output logic      [ADDR_W-1:0]  regAddr,
	output logic      [DATA_W-1:0]  regWdata,
	input  wire logic [DATA_W-1:0]  regRdata,
	input  wire logic               txPending,
	input  wire logic               rxPending,
	input  wire logic               linePending,
	input  wire logic               modemPending,
	input  wire logic               intOpenSource,
	input  wire logic               txRoom,
	input  wire logic               rxAvail,
	output logic                    intOut,
	output logic                    intOe,
	output logic                    txReadyN,
	output logic                    rxReadyN,
	output logic                    pcMode,
	output logic      [UPPER_W-1:0] pcUpperAddr
);

	function automatic logic selOk(input logic [2:0] v);
		selOk = v[P_SEL_A] & v[P_SEL_B] & ~v[P_SEL_N];
	endfunction

	uhb_state_s s;
	uhb_state_s n;

	logic [PIN_W-1:0]   pinVec;
	logic [2:0]         selLive;
	logic [ADDR_W-1:0]  addrLive;
	logic [UPPER_W-1:0] upperLive;
	logic [DATA_W-1:0]  dataLive;
	logic               asN;
	logic               rdN;
	logic               wrN;
	logic               strobeMode;
	logic               asFall;
	logic               rdFall;
	logic               rdRise;
	logic               wrFall;
	logic               wrRise;
	logic               useLive;
	logic [2:0]         selUse;
	logic [ADDR_W-1:0]  addrUse;
	logic [UPPER_W-1:0] upperUse;
	logic               selNow;
	logic               selLiveOk;
	logic               anyPending;
	logic               pcReq;

	assign pinVec = {dataIn, upperAddr, addr, strapNA, busStyleStrap, writeStrobeN,
		readStrobeN, addrLatchStrobeN, selectLowN, selectHighB, selectHighA};

	////////////////////////////////////////////////////////////////////////////////
	// decoded view of the synchronised pins

	assign selLive    = s.sync2[P_SEL_N:P_SEL_A];
	assign addrLive   = s.sync2[P_ADDR +: ADDR_W];
	assign upperLive  = s.sync2[P_UPPER +: UPPER_W];
	assign dataLive   = s.sync2[P_DATA +: DATA_W];
	assign asN        = s.sync2[P_AS_N];
	assign rdN        = s.sync2[P_RD_N];
	assign wrN        = s.sync2[P_WR_N];
	assign strobeMode = ~s.sync2[P_STYLE];
	assign asFall     = s.prevAs & ~asN;
	assign rdFall     = s.prevRd & ~rdN;
	assign rdRise     = ~s.prevRd & rdN;
	assign wrFall     = s.prevWr & ~wrN;
	assign wrRise     = ~s.prevWr & wrN;
	assign selLiveOk  = selOk(selLive);
	// a strobe held low re-latches on a read or write strobe fall unless fresh is already set, so each access captures its own address
	assign useLive    = asN | asFall | ((rdFall | wrFall) & ~s.fresh);
	assign selUse     = useLive ? selLive : s.latchSel;
	assign addrUse    = (useLive | ~strobeMode) ? addrLive : s.latchAddr;
	assign upperUse   = (useLive | ~strobeMode) ? upperLive : s.latchUpper;
	assign selNow     = strobeMode ? selOk(selUse) : selLiveOk;
	assign anyPending = txPending | rxPending | linePending | modemPending;
	assign pcReq      = ~s.sync2[P_PC_N] & ~s.sync2[P_STYLE];

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n          = s;
		n.sync1    = pinVec;
		n.sync2    = s.sync1;
		n.prevAs   = asN;
		n.prevRd   = rdN;
		n.prevWr   = wrN;
		n.prevSel  = selLiveOk;
		n.regRead  = 1'b0;
		n.regWrite = 1'b0;
		if (strobeMode) begin
			// clear first, so a new strobe edge in the same cycle still marks the capture
			if (rdRise || wrRise) begin
				n.fresh = 1'b0;
			end
			if (asFall || ((rdFall || wrFall) && !asN && !s.fresh)) begin
				n.latchSel   = selLive;
				n.latchAddr  = addrLive;
				n.latchUpper = upperLive;
				n.fresh      = 1'b1;
			end
			if (rdRise || !selNow) begin
				n.rdActive = 1'b0;
			end
			if (rdFall && selNow && !s.wrActive) begin
				n.regRead  = 1'b1;
				n.regAddr  = addrUse;
				n.rdActive = 1'b1;
			end
			if (wrFall && selNow && !s.rdActive) begin
				n.wrActive = 1'b1;
				n.regAddr  = addrUse;
			end
			// data moves on the trailing edge of the write strobe
			if (wrRise && s.wrActive) begin
				n.regWrite = 1'b1;
				n.regWdata = dataLive;
				n.wrActive = 1'b0;
			end
		end else begin
			// address strobe plays no part here
			n.fresh = 1'b0;
			if (selLiveOk && !s.prevSel) begin
				n.regAddr = addrLive;
				// direction rides on the write-strobe pin; the read strobe is unused here
				if (wrN) begin
					n.regRead  = 1'b1;
					n.rdActive = 1'b1;
				end else begin
					n.wrActive = 1'b1;
				end
			end
			if (!selLiveOk && s.prevSel) begin
				n.rdActive = 1'b0;
				if (s.wrActive) begin
					n.regWrite = 1'b1;
					n.regWdata = dataLive;
					n.wrActive = 1'b0;
				end
			end
		end
		if (s.regRead) begin
			n.dataOut = regRdata;
		end
		n.dataOe = n.rdActive & selNow & (s.regRead | s.dataOe);
		if (strobeMode) begin
			n.intOut = anyPending | intOpenSource;
			n.intOe  = ~intOpenSource | anyPending;
		end else begin
			n.intOut = 1'b0;
			n.intOe  = anyPending;
		end
		n.txRdyN  = ~txRoom;
		n.rxRdyN  = ~rxAvail;
		n.pcMode  = pcReq;
		n.pcUpper = upperUse;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= ST_RESET;
		end else begin
			s <= n;
		end
	end

	assign dataOut     = s.dataOut;
	assign dataOe      = s.dataOe;
	assign regRead     = s.regRead;
	assign regWrite    = s.regWrite;
	assign regAddr     = s.regAddr;
	assign regWdata    = s.regWdata;
	assign intOut      = s.intOut;
	assign intOe       = s.intOe;
	assign txReadyN    = s.txRdyN;
	assign rxReadyN    = s.rxRdyN;
	assign pcMode      = s.pcMode;
	assign pcUpperAddr = s.pcUpper;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence rwReadStart;
		!strobeMode && selLiveOk && !s.prevSel && wrN;
	endsequence

	sequence rwWriteEnd;
		!strobeMode && !selLiveOk && s.prevSel && s.wrActive;
	endsequence

	a_read_needs_sel: assert property (regRead |-> $past(selNow))
		else $error("register read without selection");
	a_int_any_source: assert property (anyPending |=> intOe)
		else $error("pending source not driving interrupt");
	a_int_strobe_mode: assert property (strobeMode && anyPending |=> intOut && intOe)
		else $error("strobe-mode interrupt not high");
	a_int_open_drain: assert property (!strobeMode |=> !intOut && intOe == $past(anyPending))
		else $error("open-drain interrupt wrong");
	a_as_latches: assert property (strobeMode && asFall |=> s.latchAddr == $past(addrLive))
		else $error("address not latched on strobe");
	a_as_ignored: assert property (!strobeMode && selLiveOk && !s.prevSel
		|=> regAddr == $past(addrLive))
		else $error("strobe used in rw-select mode");
	a_as_tied_low: assert property (strobeMode && rdFall && !asN && !s.fresh
		|=> s.latchAddr == $past(addrLive)
		&& (!$past(selNow && !s.wrActive) || regAddr == $past(addrLive)))
		else $error("access address not captured");
	a_tx_ready: assert property (##1 txReadyN == !$past(txRoom))
		else $error("transmit ready mismatch");
	a_rx_ready: assert property (##1 rxReadyN == !$past(rxAvail))
		else $error("receive ready mismatch");
	a_strap_n_a: assert property (##1 pcMode == $past(pcReq))
		else $error("strap_n_a mismatch");
	a_rw_read: assert property (rwReadStart |=> regRead ##1 dataOut == $past(regRdata))
		else $error("rw-select read not performed");
	a_rw_write: assert property (rwWriteEnd |=> regWrite && regWdata == $past(dataLive))
		else $error("rw-select write not performed");
	a_strobe_read: assert property (strobeMode && rdFall && selNow && !s.wrActive
		|=> regRead ##1 dataOut == $past(regRdata))
		else $error("read strobe did not read");
	a_unsel_quiet: assert property (!selNow && !s.wrActive |=> !dataOe && !regRead && !regWrite)
		else $error("activity while unselected");

endmodule // uhb_host_port

`default_nettype wire

// ==== verif/uhb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module uhb_host_model
	import uhb_pkg::*;
(
	input  wire logic              clock,
	input  wire logic [DATA_W-1:0] dataOut,
	input  wire logic              dataOe,
	output logic                   selectHighA,
	output logic                   selectHighB,
	output logic                   selectLowN,
	output logic                   addrLatchStrobeN,
	output logic      [ADDR_W-1:0] addr,
	output logic                   readStrobeN,
	output logic                   writeStrobeN,
	output wire logic [DATA_W-1:0] busLevel
);
	logic [DATA_W-1:0] hostData;

	// a released bus shows the inverse of the last value, never a stale copy
	assign busLevel = dataOe ? dataOut : hostData;

	initial begin
		{selectLowN, selectHighB, selectHighA} = 3'b100;
		addrLatchStrobeN = 1'b1;
		addr = 3'h0;
		readStrobeN = 1'b1;
		writeStrobeN = 1'b1;
		hostData = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// strobe-style cycle; asMode 0 strobe unused, 1 pulsed, 2 tied low
	task automatic stb(input logic rd, input logic [1:0] asMode, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clock);
		{selectLowN, selectHighB, selectHighA} = sel;
		addr = a;
		addrLatchStrobeN = (asMode == 2'd0);
		hostData = rd ? ~hostData : d;
		if (asMode == 2'd1) begin
			repeat (2) @(negedge clock);
			addr = ~a;
		end
		@(negedge clock);
		if (rd) readStrobeN = 1'b0;
		else writeStrobeN = 1'b0;
		repeat (6) @(negedge clock);
		readStrobeN = 1'b1;
		writeStrobeN = 1'b1;
		repeat (3) @(negedge clock);
		{selectLowN, selectHighB, selectHighA} = 3'b100;
		if (asMode != 2'd2) addrLatchStrobeN = 1'b1;
		addr = ~addr;
		hostData = ~hostData;
		repeat (4) @(negedge clock);
	endtask

	// select-window cycle; direction set up before the window opens
	task automatic rw(input logic dir, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clock);
		// read strobe low and a strobed wrong address: neither may matter in this mode
		writeStrobeN = dir;
		readStrobeN = 1'b0;
		addrLatchStrobeN = 1'b0;
		addr = ~a;
		hostData = dir ? ~hostData : d;
		@(negedge clock);
		{selectLowN, selectHighB, selectHighA} = 3'b011;
		addr = a;
		repeat (6) @(negedge clock);
		{selectLowN, selectHighB, selectHighA} = 3'b100;
		repeat (3) @(negedge clock);
		writeStrobeN = 1'b1;
		readStrobeN = 1'b1;
		addrLatchStrobeN = 1'b1;
		addr = ~addr;
		hostData = ~hostData;
		repeat (4) @(negedge clock);
	endtask
endmodule // uhb_host_model

`default_nettype wire

// ==== verif/test_uart_host_bus_select_and_status_pins.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin nMismatch++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_uart_host_bus_select_and_status_pins;
	import uhb_pkg::*;
	logic            clock, rst, style, pcN, openSrc, txRoom, rxAvail, oeSeen;
	logic      [6:0] upper;
	logic      [3:0] pend;
	logic      [2:0] rdAddr, wrAddr;
	logic      [7:0] wrData, lastOut;
	wire logic       selA, selB, selN, asN, rdN, wrN, dOe, rRd, rWr, iOut, iOe, txN, rxN, pcM;
	wire logic [2:0] a, rAddr;
	wire logic [7:0] bus, dOut, rWdata, rRdata;
	wire logic [6:0] pcUp;
	int              nMismatch, totalChecks, rdCnt, wrCnt;

	assign rRdata = 8'h50 + {5'h00, rAddr};
	always #5 clock = ~clock;

	uhb_host_model host_u (.clock(clock), .dataOut(dOut), .dataOe(dOe), .selectHighA(selA),
		.selectHighB(selB), .selectLowN(selN), .addrLatchStrobeN(asN), .addr(a),
		.readStrobeN(rdN), .writeStrobeN(wrN), .busLevel(bus));

	uhb_host_port dut_u (.clock(clock), .rst(rst), .selectHighA(selA), .selectHighB(selB),
		.selectLowN(selN), .addrLatchStrobeN(asN), .addr(a), .upperAddr(upper),
		.readStrobeN(rdN), .writeStrobeN(wrN), .busStyleStrap(style), .strapNA(pcN),
		.dataIn(bus), .dataOut(dOut), .dataOe(dOe), .regRead(rRd), .regWrite(rWr),
		.regAddr(rAddr), .regWdata(rWdata), .regRdata(rRdata), .txPending(pend[0]),
		.rxPending(pend[1]), .linePending(pend[2]), .modemPending(pend[3]),
		.intOpenSource(openSrc), .txRoom(txRoom), .rxAvail(rxAvail), .intOut(iOut),
		.intOe(iOe), .txReadyN(txN), .rxReadyN(rxN), .pcMode(pcM), .pcUpperAddr(pcUp));

	always @(negedge clock) begin
		if (rRd === 1'b1) begin
			rdCnt++;
			rdAddr = rAddr;
		end
		if (rWr === 1'b1) begin
			wrCnt++;
			{wrAddr, wrData} = {rAddr, rWdata};
		end
		if (dOe === 1'b1) {oeSeen, lastOut} = {1'b1, dOut};
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic clr();
		{rdCnt, wrCnt, oeSeen} = '0;
	endtask

	task automatic t_read(input logic [1:0] m, input logic [2:0] ad);
		clr();
		host_u.stb(1'b1, m, 3'b011, ad, 8'h00);
		`CHK(rdCnt, 1)
		`CHK(rdAddr, ad)
		`CHK({oeSeen, lastOut}, {1'b1, 8'h50 + {5'h00, ad}})
		`CHK(dOe, 1'b0)
	endtask

	task automatic t_write(input logic [2:0] ad, input logic [7:0] d);
		clr();
		host_u.stb(1'b0, 2'd0, 3'b011, ad, d);
		`CHK({wrCnt, rdCnt}, {32'd1, 32'd0})
		`CHK({wrAddr, wrData}, {ad, d})
	endtask

	// any one select off must leave the part deaf and the bus released
	task automatic t_unsel();
		logic [2:0] tbl [3];
		tbl = '{3'b111, 3'b010, 3'b001};
		for (int i = 0; i < 3; i++) begin
			clr();
			host_u.stb(1'b1, 2'd0, tbl[i], 3'h4, 8'h00);
			host_u.stb(1'b0, 2'd0, tbl[i], 3'h4, 8'h99);
			`CHK({rdCnt, wrCnt, oeSeen}, 65'h0)
		end
	endtask

	task automatic t_int();
		logic p;
		for (int m = 0; m < 3; m++) begin
			style = (m == 2);
			openSrc = (m == 1);
			for (int k = 0; k < 5; k++) begin
				pend = (k < 4) ? 4'h1 << k : 4'h0;
				p = (k < 4);
				repeat (5) @(negedge clock);
				`CHK({iOut, iOe}, (m == 0) ? {p, 1'b1} : {m == 1, p})
			end
		end
		style = 1'b0;
	endtask

	task automatic t_ready();
		for (int k = 0; k < 4; k++) begin
			{txRoom, rxAvail} = k[1:0];
			repeat (2) @(negedge clock);
			`CHK({txN, rxN}, ~k[1:0])
		end
	endtask

	task automatic t_pc();
		for (int k = 3; k >= 0; k--) begin
			{pcN, style} = k[1:0];
			upper = {k[1:0], 5'h15};
			repeat (5) @(negedge clock);
			`CHK(pcM, k == 0)
		end
		`CHK(pcUp, 7'h15)
		{pcN, style} = 2'b10;
		repeat (5) @(negedge clock);
	endtask

	task automatic t_rw();
		style = 1'b1;
		repeat (5) @(negedge clock);
		clr();
		host_u.rw(1'b1, 3'h6, 8'h00);
		`CHK({rdCnt, rdAddr, lastOut}, {32'd1, 3'h6, 8'h56})
		clr();
		host_u.rw(1'b0, 3'h1, 8'hc3);
		`CHK({wrCnt, rdCnt, wrAddr, wrData}, {32'd1, 32'd0, 3'h1, 8'hc3})
		style = 1'b0;
		repeat (5) @(negedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clock, rst, style, pcN, openSrc, txRoom, rxAvail} = 7'b0101000;
		{upper, pend, nMismatch, totalChecks} = '0;
		clr();
		repeat (12) @(negedge clock);
		`CHK({txN, rxN, dOe, rRd, rWr}, 5'b11000)
		rst = 1'b0;
		repeat (4) @(negedge clock);
		t_read(2'd0, 3'h5);
		t_read(2'd1, 3'h3);
		t_read(2'd2, 3'h2);
		t_read(2'd2, 3'h7);
		t_write(3'h2, 8'ha5);
		t_unsel();
		t_int();
		t_ready();
		t_pc();
		t_rw();
		wrap_up();
	end

	// whole sequence needs about 330 cycles; sixty times that means a hang
	initial begin
		#200000;
		nMismatch++;
		wrap_up();
	end
endmodule // test_uart_host_bus_select_and_status_pins

`default_nettype wire
